// file: rtl/adc_result_sequencer.sv
// converter result sequencer: phase results, averaging, bypass, apb
//
// Contract
// - one converter sample every 50 us unaveraged
// - 25% reset edge stores first result
// - 50%/75% edges store second, third results
// - 0% edge stores fourth result
// - 0% edge updates both combined registers
// - ready strobe rises once results valid
// - averaging accumulates phase, stores average
// - average count plus one samples
// - count zero stores single sample
// - bypass disables converter, drives analog pins
// - bypass may route reset to alarm
// - bypass ready strobe marks period start
// - phase starts after reset falling edge
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module adc_result_sequencer
  import adc_seq_pkg::*;
#(
  parameter int CONV_CYCLES_P = adc_seq_pkg::CONV_CYCLES
) (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  // timing engine
  input  wire logic                         conv_reset,
  input  wire logic                         period_start,
  // internal converter
  input  wire adc_seq_pkg::sample_t         sample,
  output logic                              conv_start,
  output logic                              converter_enable,
  // pins
  input  wire logic                         photodiode_alarm,
  output logic                              photodiode_alarm_pin,
  output logic                              analog_out_pos_en,
  output logic                              analog_out_neg_en,
  output logic                              data_ready,
  output logic                              irq
);

  import adc_seq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ctrl_t            ctrl;
    logic [STS_W-1:0] status;
    logic [STS_W-1:0] mask;
    logic             reset_d;
    edge_pos_t        edge_cnt;
    logic [15:0]      conv_timer;
    logic             conv_start;
    logic             ready_pend;
    logic             ready;
    logic             alarm_pin;
    logic [31:0]      rdata;
    logic             res_sel;
  } seq_state_t;

  seq_state_t s_r;
  seq_state_t s_nxt;

  localparam logic [15:0] CONV_RELOAD = 16'(CONV_CYCLES_P - 1);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [7:0]       idx;
  logic             hi_zero;
  logic             is_result;
  logic             is_ctrl;
  logic             is_status;
  logic             is_mask;
  logic             mapped;
  logic             setup;
  logic             access;
  logic [IDX_W-1:0] rd_slot;

  assign idx       = paddr[9:2];
  assign hi_zero   = (paddr[ADDR_W-1:10] == 2'h0);
  assign is_result = hi_zero && (idx >= IDX_PHASE_RESULT_FIRST) &&
                     (idx <= IDX_COMBINED_RESULT_SECOND_PAIR);
  assign is_ctrl   = hi_zero && (idx == IDX_AVERAGING_CONTROL_REG);
  assign is_status = hi_zero && (idx == IDX_EVENT_STATUS);
  assign is_mask   = hi_zero && (idx == IDX_EVENT_MASK);
  assign mapped    = is_result || is_ctrl || is_status || is_mask;
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign rd_slot   = IDX_W'(idx - IDX_PHASE_RESULT_FIRST);

  // zero wait: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // phase edge detection
  // ----------------------------------------------------------------
  logic      reset_rise;
  logic      reset_fall;
  edge_pos_t slot_pos;

  assign reset_rise = conv_reset && !s_r.reset_d;
  assign reset_fall = !conv_reset && s_r.reset_d;
  // period start marks the 0% edge, otherwise edges follow in order
  assign slot_pos   = period_start ? EDGE_0PCT : s_r.edge_cnt;

  // ----------------------------------------------------------------
  // accumulator and store
  // ----------------------------------------------------------------
  logic [RES_W-1:0]                average;
  logic [NUM_RES-1:0]              wr_en;
  logic [NUM_RES-1:0][RES_W-1:0]   wr_data;
  logic [RES_W-1:0]                store_rd;
  logic [NUM_RES-1:0][RES_W-1:0]   contents;
  logic                            acc_clear;
  sample_t                         acc_sample;

  // samples only count inside a conversion phase
  assign acc_sample.valid = sample.valid && !conv_reset &&
                            !s_r.ctrl.bypass;
  assign acc_sample.data  = sample.data;
  assign acc_clear        = reset_rise;

  phase_accumulator u_acc (
    .pclk          (pclk),
    .presetn       (presetn),
    .clear         (acc_clear),
    .average_count (s_r.ctrl.average_count),
    .sample        (acc_sample),
    .average       (average)
  );

  always_comb begin
    wr_en   = '0;
    wr_data = '0;
    wr_data[SLOT_FIRST]  = average;
    wr_data[SLOT_SECOND] = average;
    wr_data[SLOT_THIRD]  = average;
    wr_data[SLOT_FOURTH] = average;
    // pair differences, the fourth word taken fresh from this edge
    wr_data[SLOT_COMB0]  = contents[SLOT_FIRST] - contents[SLOT_SECOND];
    wr_data[SLOT_COMB1]  = contents[SLOT_THIRD] - average;
    if (reset_rise && !s_r.ctrl.bypass) begin
      unique case (slot_pos)
        EDGE_25PCT: begin
          wr_en[SLOT_FIRST] = 1'b1;
        end
        EDGE_50PCT: begin
          wr_en[SLOT_SECOND] = 1'b1;
        end
        EDGE_75PCT: begin
          wr_en[SLOT_THIRD] = 1'b1;
        end
        EDGE_0PCT: begin
          wr_en[SLOT_FOURTH] = 1'b1;
          wr_en[SLOT_COMB0]  = 1'b1;
          wr_en[SLOT_COMB1]  = 1'b1;
        end
      endcase
    end
  end

  result_store #(
    .W (RES_W),
    .N (NUM_RES)
  ) u_store (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (wr_en),
    .wr_data  (wr_data),
    .rd_idx   (rd_slot),
    .rd_data  (store_rd),
    .contents (contents)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [STS_W-1:0] sts_set;
  logic [STS_W-1:0] sts_clr;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.reset_d = conv_reset;
    sts_set       = '0;
    sts_clr       = '0;

    // edge position bookkeeping
    if (reset_rise) begin
      s_nxt.edge_cnt = edge_pos_t'(slot_pos + 2'h1);
    end else if (period_start) begin
      s_nxt.edge_cnt = EDGE_0PCT;
    end

    // conversion pacing, one start per conversion slot
    s_nxt.conv_start = 1'b0;
    if (s_r.ctrl.bypass || conv_reset) begin
      s_nxt.conv_timer = '0;
    end else if (reset_fall) begin
      s_nxt.conv_start = 1'b1;
      s_nxt.conv_timer = CONV_RELOAD;
    end else if (s_r.conv_timer == 16'h0000) begin
      s_nxt.conv_start = 1'b1;
      s_nxt.conv_timer = CONV_RELOAD;
    end else begin
      s_nxt.conv_timer = s_r.conv_timer - 16'h0001;
    end

    // ready strobe: outside bypass, one cycle after the store holds all six words
    s_nxt.ready_pend = 1'b0;
    s_nxt.ready      = 1'b0;
    if (s_r.ctrl.bypass) begin
      s_nxt.ready = period_start;
    end else begin
      s_nxt.ready_pend = reset_rise && (slot_pos == EDGE_0PCT);
      s_nxt.ready      = s_r.ready_pend;
    end
    sts_set[STS_READY_BIT]  = s_r.ready_pend && !s_r.ctrl.bypass;
    sts_set[STS_PERIOD_BIT] = period_start;

    // alarm pin carries the reset clock in bypass when asked to
    if (s_r.ctrl.bypass && s_r.ctrl.reset_clock_out_enable) begin
      s_nxt.alarm_pin = conv_reset;
    end else begin
      s_nxt.alarm_pin = photodiode_alarm;
    end

    // apb setup: capture read data for the access cycle
    if (setup) begin
      s_nxt.res_sel = is_result;
      s_nxt.rdata   = '0;
      if (is_ctrl) begin
        s_nxt.rdata[CTL_AVG_LSB +: AVG_W] = s_r.ctrl.average_count;
        s_nxt.rdata[CTL_BYPASS_BIT]       = s_r.ctrl.bypass;
        s_nxt.rdata[CTL_RSTCLK_BIT]       = s_r.ctrl.reset_clock_out_enable;
      end else if (is_status) begin
        s_nxt.rdata[STS_W-1:0] = s_r.status;
      end else if (is_mask) begin
        s_nxt.rdata[STS_W-1:0] = s_r.mask;
      end
    end

    // apb access: writes, and clear-on-read of the status word
    if (access && pwrite) begin
      if (is_ctrl) begin
        s_nxt.ctrl.average_count          = pwdata[CTL_AVG_LSB +: AVG_W];
        s_nxt.ctrl.bypass                 = pwdata[CTL_BYPASS_BIT];
        s_nxt.ctrl.reset_clock_out_enable = pwdata[CTL_RSTCLK_BIT];
      end else if (is_mask) begin
        s_nxt.mask = pwdata[STS_W-1:0];
      end
    end else if (access && is_status) begin
      // only bits the reader actually saw are cleared
      sts_clr = s_r.rdata[STS_W-1:0];
    end
    // result words are not touched by reads
    s_nxt.status = (s_r.status & ~sts_clr) | sts_set;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.ctrl.average_count          <= CTL_RESET[CTL_AVG_LSB +: AVG_W];
      s_r.ctrl.bypass                 <= CTL_RESET[CTL_BYPASS_BIT];
      s_r.ctrl.reset_clock_out_enable <= CTL_RESET[CTL_RSTCLK_BIT];
      s_r.status     <= STS_RESET;
      s_r.mask       <= STS_RESET;
      s_r.reset_d    <= 1'b0;
      s_r.edge_cnt   <= EDGE_0PCT;
      s_r.conv_timer <= 16'h0000;
      s_r.conv_start <= 1'b0;
      s_r.ready_pend <= 1'b0;
      s_r.ready      <= 1'b0;
      s_r.alarm_pin  <= 1'b0;
      s_r.rdata      <= 32'h0000_0000;
      s_r.res_sel    <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s_r.res_sel ? {10'h000, store_rd} : s_r.rdata;
  assign conv_start           = s_r.conv_start;
  assign converter_enable     = !s_r.ctrl.bypass;
  assign analog_out_pos_en    = s_r.ctrl.bypass;
  assign analog_out_neg_en    = s_r.ctrl.bypass;
  assign photodiode_alarm_pin = s_r.alarm_pin;
  assign data_ready           = s_r.ready;
  assign irq                  = |(s_r.status & s_r.mask);

endmodule // adc_result_sequencer

// file: rtl/adc_seq_pkg.sv
// shared constants and types of the converter result sequencer
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RES_W    = 22;
  localparam int AVG_W    = 8;
  localparam int SUM_W    = 30;
  localparam int NUM_RES  = 6;
  localparam int IDX_W    = 3;
  localparam int ADDR_W   = 12;
  localparam int STS_W    = 2;

  // ----------------------------------------------------------------
  // register indexes (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PHASE_RESULT_FIRST          = 8'h2a;
  localparam logic [7:0] IDX_PHASE_RESULT_SECOND         = 8'h2b;
  localparam logic [7:0] IDX_PHASE_RESULT_THIRD          = 8'h2c;
  localparam logic [7:0] IDX_PHASE_RESULT_FOURTH         = 8'h2d;
  localparam logic [7:0] IDX_COMBINED_RESULT_FIRST_PAIR  = 8'h2e;
  localparam logic [7:0] IDX_COMBINED_RESULT_SECOND_PAIR = 8'h2f;
  localparam logic [7:0] IDX_AVERAGING_CONTROL_REG       = 8'h30;
  localparam logic [7:0] IDX_EVENT_STATUS                = 8'h31;
  localparam logic [7:0] IDX_EVENT_MASK                  = 8'h32;

  // ----------------------------------------------------------------
  // result store slots
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] SLOT_FIRST  = 3'h0;
  localparam logic [IDX_W-1:0] SLOT_SECOND = 3'h1;
  localparam logic [IDX_W-1:0] SLOT_THIRD  = 3'h2;
  localparam logic [IDX_W-1:0] SLOT_FOURTH = 3'h3;
  localparam logic [IDX_W-1:0] SLOT_COMB0  = 3'h4;
  localparam logic [IDX_W-1:0] SLOT_COMB1  = 3'h5;

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int CTL_AVG_LSB    = 0;
  localparam int CTL_BYPASS_BIT = 8;
  localparam int CTL_RSTCLK_BIT = 9;
  localparam int STS_READY_BIT  = 0;
  localparam int STS_PERIOD_BIT = 1;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [STS_W-1:0] STS_RESET = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CONV_TIME_US  = 50;
  localparam int CONV_CYCLES   = (CONV_TIME_US * 1000000) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] data;
  } sample_t;

  typedef struct packed {
    logic [AVG_W-1:0] average_count;
    logic             bypass;
    logic             reset_clock_out_enable;
  } ctrl_t;

  typedef enum logic [1:0] {
    EDGE_0PCT  = 2'b00,
    EDGE_25PCT = 2'b01,
    EDGE_50PCT = 2'b10,
    EDGE_75PCT = 2'b11
  } edge_pos_t;

endpackage

// file: rtl/phase_accumulator.sv
// per-phase sample accumulator and running average
`timescale 1ns/1ps
module phase_accumulator
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // control
  input  wire logic                    clear,
  input  wire logic [adc_seq_pkg::AVG_W-1:0] average_count,
  // converter samples
  input  wire adc_seq_pkg::sample_t    sample,
  // result
  output logic [adc_seq_pkg::RES_W-1:0] average
);

  typedef struct packed {
    logic signed [SUM_W-1:0] sum;
    logic [AVG_W:0]          taken;
    logic [RES_W-1:0]        avg;
  } acc_state_t;

  acc_state_t s_r;
  acc_state_t s_nxt;
  logic signed [SUM_W-1:0] ext;
  logic [AVG_W:0]          limit;

  assign ext   = SUM_W'(signed'(sample.data));
  assign limit = {1'b0, average_count} + 9'h001;

  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      s_nxt.sum   = '0;
      s_nxt.taken = '0;
    end
    // extra samples beyond the programmed count plus one are dropped
    if (sample.valid && (s_nxt.taken < limit)) begin
      s_nxt.sum   = s_nxt.sum + ext;
      s_nxt.taken = s_nxt.taken + 9'h001;
      // divide by samples actually taken, so a short phase stays sane
      s_nxt.avg   = RES_W'(s_nxt.sum / signed'({1'b0, s_nxt.taken}));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign average = s_r.avg;

endmodule // phase_accumulator

// file: rtl/result_store.sv
// result word store with registered read port
`timescale 1ns/1ps
module result_store #(
  parameter int W = 22,
  parameter int N = 6
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // write side
  input  wire logic [N-1:0]         wr_en,
  input  wire logic [N-1:0][W-1:0]  wr_data,
  // read side
  input  wire logic [$clog2(N)-1:0] rd_idx,
  output logic [W-1:0]              rd_data,
  output logic [N-1:0][W-1:0]       contents
);

  typedef struct packed {
    logic [N-1:0][W-1:0] mem;
    logic [W-1:0]        rd;
  } store_state_t;

  store_state_t s_r;
  store_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < N; i++) begin
      if (wr_en[i]) begin
        s_nxt.mem[i] = wr_data[i];
      end
    end
    s_nxt.rd = (int'(rd_idx) < N) ? s_r.mem[rd_idx] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data  = s_r.rd;
  assign contents = s_r.mem;

endmodule // result_store

// file: tb/converter_model.sv
// behavioural model of the converter feeding the result sequencer
`timescale 1ns/1ps
module converter_model
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // converter control
  input  wire logic           conv_start,
  input  wire logic           converter_enable,
  // converter result
  output adc_seq_pkg::sample_t sample
);
  import adc_seq_pkg::*;

  int wait_n;

  // idle data toggles so a stale word never passes as fresh
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_n = 0;
      sample <= '0;
    end else begin
      sample <= (wait_n == 1) ? {1'b1, 22'($urandom)} : {1'b0, ~sample.data};
      if (wait_n > 0) wait_n--;
      if (conv_start && converter_enable) wait_n = $urandom_range(5, 1);
    end
  end

endmodule // converter_model

// file: tb/adc_result_sequencer_checker.sv
// port assertions of the converter result sequencer
`timescale 1ns/1ps
module adc_result_sequencer_checker
  import adc_seq_pkg::*;
#(
  parameter int CONV_CYCLES_P = adc_seq_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic                           pclk,
  input wire logic                           presetn,
  // apb
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
  input wire logic                           pslverr,
  // sequencing and pins
  input wire logic                           conv_reset,
  input wire logic                           period_start,
  input wire logic                           conv_start,
  input wire logic                           converter_enable,
  input wire logic                           photodiode_alarm,
  input wire logic                           photodiode_alarm_pin,
  input wire logic                           analog_out_pos_en,
  input wire logic                           analog_out_neg_en,
  input wire logic                           data_ready
);
  import adc_seq_pkg::*;

  // ----------------------------------------------------------------
  // conversion spacing counter
  // ----------------------------------------------------------------
  logic [15:0] gap_r;
  logic        armed_r;

  // first start after reset or bypass is exempt from spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r   <= 16'h0;
      armed_r <= 1'b0;
    end else begin
      gap_r   <= (conv_start || conv_reset) ? 16'h0 : gap_r + 16'h1;
      armed_r <= converter_enable && (armed_r || conv_start);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_zero : assert property (
    converter_enable && $rose(conv_reset) && period_start
    |-> ##2 data_ready ##1 !data_ready)
    else $error("no ready after period edge");
  a_ready_bypass : assert property (
    !converter_enable && period_start |=> data_ready ##1 !data_ready)
    else $error("no bypass ready");
  a_ready_cause : assert property (
    data_ready |-> $past(period_start) || $past(period_start, 2))
    else $error("ready without period");
  a_alarm_normal : assert property (
    $past(presetn) && converter_enable && $past(converter_enable)
    |-> photodiode_alarm_pin == $past(photodiode_alarm))
    else $error("alarm pin not following");
  a_alarm_source : assert property (
    photodiode_alarm_pin
    |-> $past(photodiode_alarm) || (!converter_enable && $past(conv_reset)))
    else $error("alarm pin sourceless");
  a_analog_bypass : assert property (
    analog_out_pos_en == !converter_enable
    && analog_out_neg_en == !converter_enable)
    else $error("analog enables wrong");
  a_no_start_bypass : assert property (
    !converter_enable && !$past(converter_enable) |-> !conv_start)
    else $error("start in bypass");
  a_start_after_fall : assert property (
    converter_enable && $fell(conv_reset) |=> conv_start)
    else $error("no start after reset");
  a_start_pace : assert property (
    conv_start && armed_r && !$past(conv_reset, 2)
    |-> gap_r == 16'(CONV_CYCLES_P - 1))
    else $error("start spacing wrong");
  a_slverr_map : assert property (
    pslverr == (psel && penable && (paddr[11:10] != 2'h0
      || paddr[9:2] < IDX_PHASE_RESULT_FIRST
      || paddr[9:2] > IDX_EVENT_MASK)))
    else $error("slave error wrong");

endmodule // adc_result_sequencer_checker

bind adc_result_sequencer adc_result_sequencer_checker #(
  .CONV_CYCLES_P(CONV_CYCLES_P)
) i_adc_result_sequencer_checker (.*);

// file: tb/adc_result_averaging_sequencer_bench.sv
// self-checking bench of the converter result sequencer
`timescale 1ns/1ps
module adc_result_averaging_sequencer_bench;
  import adc_seq_pkg::*;

  // ----------------------------------------------------------------
  // signals and bench state
  // ----------------------------------------------------------------
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = 32'h0;
  logic              conv_reset = 1'b0;
  logic              period_start = 1'b0;
  logic              photodiode_alarm = 1'b0;
  logic [31:0]       prdata;
  logic              pready, pslverr, conv_start, converter_enable;
  logic              photodiode_alarm_pin, data_ready, irq;
  logic              analog_out_pos_en, analog_out_neg_en;
  sample_t           sample;
  int                n_fail = 0;
  int                checks_done = 0;
  int                n_start, n_rdy, sum, n, k;
  int                cnts[4] = '{0, 1, 3, 7};
  logic              cnt_on = 1'b0;
  logic              cr_q = 1'b0;
  logic [9:0]        ctl = 10'h0;
  logic [21:0]       last = 22'h0;
  logic [21:0]       e[6] = '{default: 22'h0};

  adc_result_sequencer #(.CONV_CYCLES_P(20)) i_adc_result_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_reset(conv_reset),
    .period_start(period_start), .sample(sample),
    .conv_start(conv_start), .converter_enable(converter_enable),
    .photodiode_alarm(photodiode_alarm),
    .photodiode_alarm_pin(photodiode_alarm_pin),
    .analog_out_pos_en(analog_out_pos_en),
    .analog_out_neg_en(analog_out_neg_en),
    .data_ready(data_ready), .irq(irq));

  converter_model i_converter_model (
    .pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .converter_enable(converter_enable), .sample(sample));

  initial forever #2.5 pclk = ~pclk;

  always @(posedge pclk) photodiode_alarm <= 1'($urandom);

  always @(posedge pclk) begin
    if (cnt_on) begin
      n_start += int'(conv_start === 1'b1 && conv_reset === 1'b0);
      n_rdy   += int'(data_ready === 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // reference model of the result words
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (!presetn) begin
      sum = 0;
      n = 0;
      k = 0;
    end else if (!ctl[8]) begin
      if (conv_reset && !cr_q) begin
        if (n > 0) last = 22'(sum / n);
        k = period_start ? 0 : k + 1;
        if (k == 0) begin
          e[3] = last;
          e[4] = e[0] - e[1];
          e[5] = e[2] - e[3];
        end else if (k < 4) begin
          e[k-1] = last;
        end
        sum = 0;
        n = 0;
      end else if (sample.valid && !conv_reset && n <= ctl[7:0]) begin
        sum += int'($signed(sample.data));
        n++;
      end
    end
    cr_q = conv_reset;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      n_fail++;
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, input logic [31:0] ex);
    int   t;
    logic bad;
    bad = idx < IDX_PHASE_RESULT_FIRST || idx > IDX_EVENT_MASK;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    chk("pready", 32'h1, 32'(pready));
    chk("pslverr", 32'(bad), 32'(pslverr));
    if (!wr) chk("prdata", bad ? 32'h0 : ex, prdata);
    if (wr && idx == IDX_AVERAGING_CONTROL_REG) ctl <= wd[9:0];
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // two-cycle reset pulses at each quarter
  task automatic periods(input int np);
    n_start = 0;
    n_rdy   = 0;
    cnt_on <= 1'b1;
    for (int q = 0; q < 4 * np; q++) begin
      period_start <= (q % 4 == 0);
      conv_reset   <= 1'b1;
      @(posedge pclk);
      period_start <= 1'b0;
      @(posedge pclk);
      conv_reset <= 1'b0;
      repeat (70) @(posedge pclk);
    end
    cnt_on <= 1'b0;
  endtask

  task automatic read_results();
    for (int j = 0; j < 12; j++) begin
      acc(1'b0, IDX_PHASE_RESULT_FIRST + 8'(j % 6), 32'h0,
          {10'h0, e[j % 6]});
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    test_done;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(99));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("converter_enable", 32'h1, 32'(converter_enable));
    chk("analog_out_pos_en", 32'h0, 32'(analog_out_pos_en));
    acc(1'b1, IDX_PHASE_RESULT_FIRST, $urandom, 32'h0);
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, IDX_PHASE_RESULT_FIRST + 8'(i), 32'h0, 32'h0);
    end
    acc(1'b0, 8'h33, 32'h0, 32'h0);
    acc(1'b1, 8'h40, $urandom, 32'h0);
    $display("map test done");
    foreach (cnts[i]) begin
      acc(1'b1, IDX_EVENT_MASK, 32'(i != 0), 32'h0);
      acc(1'b1, IDX_AVERAGING_CONTROL_REG, 32'(cnts[i]), 32'h0);
      acc(1'b0, IDX_AVERAGING_CONTROL_REG, 32'h0, 32'(cnts[i]));
      periods(2);
      chk("conv_start count", 32'd32, 32'(n_start));
      chk("data_ready count", 32'd2, 32'(n_rdy));
      chk("irq", 32'(i != 0), 32'(irq));
      read_results();
      acc(1'b0, IDX_EVENT_STATUS, 32'h0, 32'h3);
      acc(1'b0, IDX_EVENT_STATUS, 32'h0, 32'h0);
      chk("irq", 32'h0, 32'(irq));
      $display("count %0d test done", cnts[i]);
    end
    acc(1'b1, IDX_AVERAGING_CONTROL_REG, 32'h303, 32'h0);
    acc(1'b0, IDX_AVERAGING_CONTROL_REG, 32'h0, 32'h303);
    chk("converter_enable", 32'h0, 32'(converter_enable));
    chk("analog_out_neg_en", 32'h1, 32'(analog_out_neg_en));
    periods(2);
    chk("conv_start count", 32'h0, 32'(n_start));
    chk("data_ready count", 32'd2, 32'(n_rdy));
    read_results();
    acc(1'b1, IDX_AVERAGING_CONTROL_REG, 32'h100, 32'h0);
    periods(1);
    chk("data_ready count", 32'd1, 32'(n_rdy));
    acc(1'b1, IDX_AVERAGING_CONTROL_REG, 32'h0, 32'h0);
    chk("converter_enable", 32'h1, 32'(converter_enable));
    $display("bypass test done");
    test_done;
  end

endmodule // adc_result_averaging_sequencer_bench
